// *** esp_regs.svh ***
`ifndef ESP_REGS_SVH
`define ESP_REGS_SVH
// Register byte offsets.
`define ESP_CTRL_OFS 8'h00
`define ESP_IEN_OFS 8'h04
`define ESP_STAT_OFS 8'h08
`define ESP_DATA_OFS 8'h0C
`define ESP_BAUD_OFS 8'h10
`define ESP_TXD_OFS 8'h14
`define ESP_MODE_OFS 8'h18
// Control bit positions.
`define ESP_CTRL_EN 0
`define ESP_CTRL_WAKE 1
`define ESP_CTRL_ICS 2
`define ESP_CTRL_M 3
`define ESP_CTRL_PEN 4
`define ESP_CTRL_PTY 5
`define ESP_CTRL_STBY 6
`define ESP_CTRL_BRK 7
// Interrupt enable bit positions.
`define ESP_IE_TXE 0
`define ESP_IE_TXC 1
`define ESP_IE_RXF 2
`define ESP_IE_IDLE 3
`define ESP_IE_OR 4
`define ESP_IE_NF 5
`define ESP_IE_FE 6
`define ESP_IE_PE 7
// Status bit positions.
`define ESP_ST_TXE 0
`define ESP_ST_TXC 1
`define ESP_ST_RXF 2
`define ESP_ST_IDLE 3
`define ESP_ST_OR 4
`define ESP_ST_NF 5
`define ESP_ST_FE 6
`define ESP_ST_PE 7
// Mode register bit positions.
`define ESP_MODE_STOP 0
`define ESP_MODE_DBG 1
`define ESP_MODE_BCA 2
// Reset values and timing.
`define ESP_CTRL_RST 8'h00
`define ESP_IEN_RST 8'h00
`define ESP_BAUD_RST 16'h0019
`define ESP_TICKS 5'd16
`define ESP_SAMP_A 4'd7
`define ESP_SAMP_B 4'd8
`define ESP_SAMP_C 4'd9
`define ESP_START_A 4'd2
`define ESP_START_B 4'd4
`define ESP_START_C 4'd6
`endif

// *** esp_pkg.sv ***
package esp_pkg;
  typedef enum logic [1:0] {
    ESP_IDLE = 2'b00,
    ESP_START = 2'b01,
    ESP_DATA = 2'b10,
    ESP_STOP = 2'b11
  } esp_rx_state_t;
  typedef enum logic [1:0] {
    ESP_TX_IDLE = 2'b00,
    ESP_TX_SHIFT = 2'b01
  } esp_tx_state_t;
endpackage

// *** esp_tick_gen.sv ***
`timescale 1ns/1ns
`include "esp_regs.svh"
module esp_tick_gen
  import esp_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic run,
  input wire logic [15:0] divisor,
  // Oversample tick.
  output logic tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  wire at_end = (cnt_reg >= divisor) || (divisor == 16'h0000);
  assign cnt_next = at_end ? 16'h0000 : cnt_reg + 16'h0001;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= at_end;
    end
  end
endmodule

// *** esp_core.sv ***
`timescale 1ns/1ns
`include "esp_regs.svh"
// Summary of operation
// - Oversample tick runs at sixteen times baud and times all bit sampling.
// - Stop bit sampled at oversample ticks 8, 9 and 10.
// - One missed stop sample flags noise; more than one flags framing error.
// - Tick counter resynchronises on each valid falling edge inside a character.
// - Setting receiver standby suppresses rx_irq requests; err_irq requests are not masked.
// - Wake select set: character with MSB one clears standby, sets rx full.
// - Wake select clear: idle character clears standby, sets no idle or full.
// - Idle count start selects counting ones after start or after stop bit.
// - Wake select clear: setting standby on an idle line wakes again.
// - Buffer moving to shift register sets tx empty, interrupt if enabled.
// - Tx complete set when shifter and buffer empty; interrupt if enabled.
// - Character into data buffer sets rx full; interrupt if enabled.
// - Idle flag after 10 or 11 ones by length; interrupt if enabled.
// - Unread buffer keeps old character, new lost, overrun set, error request.
// - Noise in start, data or stop bits sets noise flag, error request.
// - Zero where stop bit expected sets framing error, error request.
// - Parity check failure sets parity flag, error request.
// - Keeps operating in wait mode; enabled requests wake the processor.
// - Stop mode halts operation keeping registers; resumes at exit.
// - Break with clear allowed: clears act and stay after break.
// - Break with clear disallowed: accesses leave flags; two-step clear resumes after.
module esp_core
  import esp_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins.
  input wire logic rxd,
  output logic txd,
  // Interrupt requests.
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq
);
  logic [7:0] ctrl_reg;
  logic [7:0] ien_reg;
  logic [15:0] baud_reg;
  logic [2:0] mode_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [8:0] rx_buf_reg;
  logic [7:0] txd_buf_reg;
  logic txd_full_reg;
  logic [1:0] clr_armed_reg;
  logic [7:0] armed_reg;
  logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
  esp_rx_state_t rx_state_reg;
  logic [3:0] tick_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [9:0] sh_reg;
  logic [2:0] samp_reg;
  logic rx_noise_reg;
  logic last_bit_reg;
  logic [3:0] ones_reg;
  logic idle_seen_reg;
  esp_tx_state_t tx_state_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_bits_reg;
  logic [3:0] tx_tick_reg;
  logic tick;
  // Write handshake holding registers.
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  function automatic logic mixed3(input logic [2:0] s);
    mixed3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  wire stopped = mode_reg[`ESP_MODE_STOP];
  wire enabled = ctrl_reg[`ESP_CTRL_EN] && !stopped;
  wire nine = ctrl_reg[`ESP_CTRL_M];
  wire [3:0] char_bits = nine ? 4'd10 : 4'd9;
  esp_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enabled),
    .divisor(baud_reg),
    .tick(tick)
  );

  // Bus handshake.
  wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire rd_data = do_read && (s_axi_araddr == `ESP_DATA_OFS);
  wire rd_stat = do_read && (s_axi_araddr == `ESP_STAT_OFS);
  wire wr_hit = do_write && w_strb_reg[0];
  wire wr_ctrl = wr_hit && (aw_addr_reg == `ESP_CTRL_OFS);
  wire wr_stat = wr_hit && (aw_addr_reg == `ESP_STAT_OFS);
  wire wr_txd = wr_hit && (aw_addr_reg == `ESP_TXD_OFS) && enabled;
  wire in_dbg = mode_reg[`ESP_MODE_DBG];
  wire clr_ok = !in_dbg || mode_reg[`ESP_MODE_BCA];
  wire known = (s_axi_araddr <= `ESP_MODE_OFS) && (s_axi_araddr[1:0] == 2'b00);
  wire wknown = (aw_addr_reg <= `ESP_MODE_OFS) && (aw_addr_reg[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wknown ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `ESP_CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_reg};
        `ESP_IEN_OFS: s_axi_rdata <= {24'h000000, ien_reg};
        `ESP_STAT_OFS: s_axi_rdata <= {24'h000000, stat_reg};
        `ESP_DATA_OFS: s_axi_rdata <= {23'h000000, rx_buf_reg};
        `ESP_BAUD_OFS: s_axi_rdata <= {16'h0000, baud_reg};
        `ESP_MODE_OFS: s_axi_rdata <= {29'h00000000, mode_reg};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control registers; standby is also cleared by wakeup below.
  logic wake_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `ESP_CTRL_RST;
      ien_reg <= `ESP_IEN_RST;
      baud_reg <= `ESP_BAUD_RST;
      mode_reg <= 3'b000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= w_data_reg[7:0];
      end else if (wake_evt) begin
        ctrl_reg[`ESP_CTRL_STBY] <= 1'b0;
      end
      if (wr_hit && aw_addr_reg == `ESP_IEN_OFS) begin
        ien_reg <= w_data_reg[7:0];
      end
      if (wr_hit && aw_addr_reg == `ESP_BAUD_OFS) begin
        baud_reg <= w_data_reg[15:0];
      end
      if (wr_hit && aw_addr_reg == `ESP_MODE_OFS) begin
        mode_reg <= w_data_reg[2:0];
      end
    end
  end

  // Receive pin synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
      if (tick) begin
        rx_prev_reg <= rx_s2_reg;
      end
    end
  end

  // Receiver sequencer.
  wire rx_run = tick && enabled;
  wire fall = rx_prev_reg && !rx_s2_reg;
  wire at_a = tick_cnt_reg == `ESP_SAMP_A;
  wire at_b = tick_cnt_reg == `ESP_SAMP_B;
  wire at_c = tick_cnt_reg == `ESP_SAMP_C;
  wire [2:0] samp_now = {samp_reg[1:0], rx_s2_reg};
  wire bit_val = maj3(samp_now);
  wire bit_end = rx_run && at_c;
  wire start_bad = rx_run && (rx_state_reg == ESP_START) && (tick_cnt_reg == `ESP_START_C) &&
                   maj3(samp_now);
  wire char_done = bit_end && (rx_state_reg == ESP_STOP);
  wire stop_fe = char_done && !bit_val;
  wire stop_nf = char_done && mixed3(samp_now);
  wire [8:0] rx_word = nine ? sh_reg[9:1] : {1'b0, sh_reg[9:2]};
  wire msb = nine ? sh_reg[9] : sh_reg[9];
  wire par_bad = ctrl_reg[`ESP_CTRL_PEN] && ((^rx_word) ^ ctrl_reg[`ESP_CTRL_PTY]);
  wire stby = ctrl_reg[`ESP_CTRL_STBY];
  wire wake_sel = ctrl_reg[`ESP_CTRL_WAKE];
  wire addr_wake = char_done && stby && wake_sel && msb;
  wire accept = char_done && (!stby || addr_wake);
  wire line_idle = ones_reg >= (char_bits + 4'd1);
  wire idle_wake = stby && !wake_sel && line_idle && enabled;
  assign wake_evt = addr_wake || idle_wake;
  wire idle_set = rx_run && line_idle && !idle_seen_reg && !stby;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= ESP_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 10'h000;
      samp_reg <= 3'b111;
      rx_noise_reg <= 1'b0;
      last_bit_reg <= 1'b1;
    end else if (rx_run) begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
      if (at_a || at_b || tick_cnt_reg == `ESP_START_A || tick_cnt_reg == `ESP_START_B) begin
        samp_reg <= {samp_reg[1:0], rx_s2_reg};
      end
      case (rx_state_reg)
        ESP_IDLE: begin
          rx_noise_reg <= 1'b0;
          if (fall) begin
            rx_state_reg <= ESP_START;
            tick_cnt_reg <= 4'h0;
          end
        end
        ESP_START: begin
          if (tick_cnt_reg == `ESP_START_C) begin
            rx_noise_reg <= mixed3(samp_now);
            if (start_bad) begin
              rx_state_reg <= ESP_IDLE;
            end
          end
          if (at_c) begin
            rx_state_reg <= ESP_DATA;
            bit_cnt_reg <= 4'h0;
            last_bit_reg <= 1'b0;
          end
        end
        ESP_DATA: begin
          if (fall && last_bit_reg && (tick_cnt_reg > `ESP_SAMP_C || tick_cnt_reg < `ESP_SAMP_A)) begin
            tick_cnt_reg <= 4'h0;
          end
          if (at_c) begin
            sh_reg <= {bit_val, sh_reg[9:1]};
            last_bit_reg <= bit_val;
            rx_noise_reg <= rx_noise_reg | mixed3(samp_now);
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == char_bits - 4'd2) begin
              rx_state_reg <= ESP_STOP;
            end
          end
        end
        ESP_STOP: begin
          if (at_c) begin
            rx_state_reg <= ESP_IDLE;
          end
        end
        default: rx_state_reg <= ESP_IDLE;
      endcase
    end
  end

  // Ones counted to 10 or 11.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_reg <= 4'h0;
      idle_seen_reg <= 1'b0;
    end else if (bit_end) begin
      if (!bit_val || (rx_state_reg == ESP_START) ||
          (ctrl_reg[`ESP_CTRL_ICS] && rx_state_reg == ESP_DATA)) begin
        ones_reg <= 4'h0;
        idle_seen_reg <= 1'b0;
      end else if (!line_idle) begin
        ones_reg <= ones_reg + 4'h1;
      end else begin
        idle_seen_reg <= 1'b1;
      end
    end else if (rx_run && rx_state_reg == ESP_IDLE && tick_cnt_reg == 4'hF && !line_idle) begin
      ones_reg <= ones_reg + 4'h1;
    end else if (idle_set || idle_wake) begin
      idle_seen_reg <= 1'b1;
    end
  end

  // Transmitter.
  wire tx_load = enabled && (tx_state_reg == ESP_TX_IDLE) && txd_full_reg && tick;
  wire tx_bit = tick && (tx_tick_reg == 4'hF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= ESP_TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_bits_reg <= 4'h0;
      tx_tick_reg <= 4'h0;
      txd <= 1'b1;
      txd_full_reg <= 1'b0;
      txd_buf_reg <= 8'h00;
    end else begin
      if (wr_txd) begin
        txd_buf_reg <= w_data_reg[7:0];
        txd_full_reg <= 1'b1;
      end else if (tx_load) begin
        txd_full_reg <= 1'b0;
      end
      if (tick && enabled) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
      end
      if (tx_load) begin
        tx_state_reg <= ESP_TX_SHIFT;
        tx_sh_reg <= {2'b11, txd_buf_reg, 1'b0};
        tx_bits_reg <= 4'd10;
        tx_tick_reg <= 4'h0;
        txd <= 1'b0;
      end else if (tx_state_reg == ESP_TX_SHIFT && tx_bit) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        txd <= tx_sh_reg[1];
        tx_bits_reg <= tx_bits_reg - 4'h1;
        if (tx_bits_reg == 4'h1) begin
          tx_state_reg <= ESP_TX_IDLE;
        end
      end
    end
  end
  wire tx_done = (tx_state_reg == ESP_TX_SHIFT) && tx_bit && (tx_bits_reg == 4'h1) && !txd_full_reg;

  // Status flags: a set in the same cycle as a clear wins.
  // Two-step clear.
  wire stat_clr = clr_ok && wr_stat;
  wire [7:0] arm_clr = (rd_stat && clr_ok) ? stat_reg : 8'h00;
  wire rx_step2 = rd_data && clr_ok && armed_reg[`ESP_ST_RXF];
  always_comb begin
    stat_next = stat_reg;
    if (stat_clr) begin
      stat_next = stat_reg & ~w_data_reg[7:0];
    end
    if (rx_step2) begin
      stat_next = stat_next & 8'hC3;
    end
    if (wr_txd && clr_ok) begin
      stat_next[`ESP_ST_TXE] = 1'b0;
      stat_next[`ESP_ST_TXC] = 1'b0;
    end
    if (tx_load) begin
      stat_next[`ESP_ST_TXE] = 1'b1;
    end
    if (tx_done) begin
      stat_next[`ESP_ST_TXC] = 1'b1;
    end
    if (accept && stat_reg[`ESP_ST_RXF]) begin
      stat_next[`ESP_ST_OR] = 1'b1;
    end else if (accept) begin
      stat_next[`ESP_ST_RXF] = 1'b1;
      stat_next[`ESP_ST_NF] = stat_next[`ESP_ST_NF] | rx_noise_reg | stop_nf;
      stat_next[`ESP_ST_FE] = stat_next[`ESP_ST_FE] | stop_fe;
      stat_next[`ESP_ST_PE] = stat_next[`ESP_ST_PE] | par_bad;
    end
    if (idle_set) begin
      stat_next[`ESP_ST_IDLE] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 8'h03;
      armed_reg <= 8'h00;
      rx_buf_reg <= 9'h000;
    end else begin
      stat_reg <= stat_next;
      if (rd_stat && clr_ok) begin
        armed_reg <= arm_clr;
      end else if (rx_step2) begin
        armed_reg <= 8'h00;
      end
      if (accept && !stat_reg[`ESP_ST_RXF]) begin
        rx_buf_reg <= stop_fe && rx_word == 9'h000 ? 9'h000 : rx_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      tx_irq <= |(stat_reg[1:0] & ien_reg[1:0]);
      rx_irq <= !stby && |(stat_reg[3:2] & ien_reg[3:2]);
      err_irq <= |(stat_reg[7:4] & ien_reg[7:4]);
    end
  end

  property p_err_or;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> err_irq == $past(|(stat_reg[7:4] & ien_reg[7:4]));
  endproperty
  a_err_or: assert property (p_err_or) else $error("error request mismatch");
  property p_stby_mask;
    @(posedge aclk) disable iff (!aresetn)
      $past(stby) |-> !rx_irq;
  endproperty
  a_stby_mask: assert property (p_stby_mask) else $error("rx request in standby");
  property p_overrun;
    @(posedge aclk) disable iff (!aresetn)
      accept && stat_reg[`ESP_ST_RXF] |=> stat_reg[`ESP_ST_OR] && rx_buf_reg == $past(rx_buf_reg);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost old data");
  property p_rxf;
    @(posedge aclk) disable iff (!aresetn)
      accept |=> stat_reg[`ESP_ST_RXF];
  endproperty
  a_rxf: assert property (p_rxf) else $error("rx full not set");
  property p_fe;
    @(posedge aclk) disable iff (!aresetn)
      accept && stop_fe && !stat_reg[`ESP_ST_RXF] |=> stat_reg[`ESP_ST_FE];
  endproperty
  a_fe: assert property (p_fe) else $error("framing flag missed");
  property p_addr_wake;
    @(posedge aclk) disable iff (!aresetn)
      addr_wake && !wr_ctrl |=> !stby ##0 stat_reg[`ESP_ST_RXF];
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("address wake failed");
  property p_idle_wake;
    @(posedge aclk) disable iff (!aresetn)
      idle_wake && !wr_ctrl |=> !stby && !$rose(stat_reg[`ESP_ST_IDLE]);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");
  property p_txe;
    @(posedge aclk) disable iff (!aresetn)
      tx_load |=> stat_reg[`ESP_ST_TXE] && tx_state_reg == ESP_TX_SHIFT;
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty not set");
  property p_break_hold;
    @(posedge aclk) disable iff (!aresetn)
      in_dbg && !mode_reg[`ESP_MODE_BCA] |=> (stat_reg & $past(stat_reg)) == $past(stat_reg);
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("flag cleared in break");
endmodule

// *** esp_ser_src.sv ***
`timescale 1ns/1ns
module esp_ser_src (
  // Clock.
  input wire logic aclk,
  // Serial line toward the receiver.
  output logic line
);
  initial line = 1'b1;
  // A frame is start, eight bits LSB first, then stop; the line rests high between frames.
  task automatic send(input logic [7:0] d, input logic stop, input int per);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (per) @(posedge aclk);
    end
    // A missing stop bit is followed by one idle bit time, so the next start edge can be seen.
    if (!stop) begin
      line <= 1'b1;
      repeat (per) @(posedge aclk);
    end
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "esp_regs.svh"
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata, rd_v, ex;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r;
  logic rxd, txd, tx_irq, rx_irq, err_irq;
  int num_errors, comparisons, per;
  logic [7:0] q[$];
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  esp_ser_src u_esp_ser_src (.aclk(aclk), .line(rxd));
  esp_core u_esp_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd), .txd(txd),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, where values are settled for the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    for (int n = 0; n < 50 && !b_ok; n++) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check(b_ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    for (int n = 0; n < 50 && !r_ok; n++) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd_v = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check(r_ok, 1'b1);
  endtask
  task automatic wait_tx();
    @(negedge aclk);
    for (int n = 0; n < 3000 && tx_irq !== 1'b1; n++) @(negedge aclk);
    check(tx_irq, 1'b1);
  endtask
  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    void'($urandom(11));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ESP_STAT_OFS); check(rd_v, 32'h03);
    rd(`ESP_BAUD_OFS); check(rd_v, 32'h19);
    rd(`ESP_CTRL_OFS); check(rd_v, 32'h00);
    rd(8'h1C); check(rd_v, 32'h0); check(rd_r, 2'b10);
    // Divisor 3 gives a bit time of 64 clocks.
    wr(`ESP_BAUD_OFS, 32'h3);
    wr(`ESP_IEN_OFS, 32'h14);
    // Rows: fast clean, framing error, parity error, slow clean.
    for (int r = 0; r < 4; r++) begin
      d = (r == 2) ? 8'h01 : 8'($urandom);
      per = (r == 0) ? 62 : (r == 3) ? 66 : 64;
      ex = 32'h04 | ((r == 1) ? 32'h40 : 32'h0) | ((r == 2) ? 32'h80 : 32'h0);
      wr(`ESP_CTRL_OFS, (r == 2) ? 32'h11 : 32'h01);
      wr(`ESP_STAT_OFS, 32'hFF);
      q.push_back(d);
      u_esp_ser_src.send(d, r != 1, per);
      repeat (20) @(posedge aclk);
      check(rx_irq, 1'b1);
      check(err_irq, 1'b0);
      rd(`ESP_STAT_OFS); check(rd_v & 32'hF4, ex);
      rd(`ESP_DATA_OFS);
      ex = q.pop_front();
      if (r != 2) check(rd_v, ex);
      repeat (768) @(posedge aclk);
      rd(`ESP_STAT_OFS); check(rd_v & 32'h08, 32'h08);
    end
    // An all-ones character ends the idle count early only when counting starts after the start bit.
    for (int j = 0; j < 2; j++) begin
      wr(`ESP_CTRL_OFS, j ? 32'h05 : 32'h01);
      wr(`ESP_STAT_OFS, 32'hFF);
      u_esp_ser_src.send(8'hFF, 1'b1, 64);
      repeat (40) @(posedge aclk);
      rd(`ESP_STAT_OFS);
      check(rd_v & 32'h0C, j ? 32'h04 : 32'h0C);
      rd(`ESP_DATA_OFS);
      check(rd_v, 32'hFF);
      repeat (768) @(posedge aclk);
    end
    wr(`ESP_CTRL_OFS, 32'h01);
    wr(`ESP_STAT_OFS, 32'hFF);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      q.push_back(d);
      u_esp_ser_src.send(d, 1'b1, 64);
    end
    repeat (20) @(posedge aclk);
    check(err_irq, 1'b1);
    rd(`ESP_STAT_OFS); check(rd_v & 32'h14, 32'h14);
    rd(`ESP_DATA_OFS); check(rd_v, q[0]);
    q.delete();
    wr(`ESP_CTRL_OFS, 32'h43);
    wr(`ESP_STAT_OFS, 32'hFF);
    u_esp_ser_src.send(8'h12, 1'b1, 64);
    repeat (20) @(posedge aclk);
    check(rx_irq, 1'b0);
    rd(`ESP_CTRL_OFS); check(rd_v, 32'h43);
    u_esp_ser_src.send(8'h92, 1'b1, 64);
    repeat (20) @(posedge aclk);
    rd(`ESP_CTRL_OFS); check(rd_v, 32'h03);
    rd(`ESP_STAT_OFS); check(rd_v & 32'h04, 32'h04);
    rd(`ESP_DATA_OFS); check(rd_v, 32'h92);
    repeat (768) @(posedge aclk);
    wr(`ESP_STAT_OFS, 32'hFF);
    wr(`ESP_CTRL_OFS, 32'h41);
    repeat (768) @(posedge aclk);
    rd(`ESP_CTRL_OFS); check(rd_v, 32'h01);
    rd(`ESP_STAT_OFS); check(rd_v & 32'h0C, 32'h00);
    wr(`ESP_IEN_OFS, 32'h01);
    wr(`ESP_TXD_OFS, 32'h5A);
    wait_tx();
    check(txd, 1'b0);
    wr(`ESP_IEN_OFS, 32'h02);
    @(negedge aclk);
    check(tx_irq, 1'b0);
    wait_tx();
    check(txd, 1'b1);
    rd(`ESP_STAT_OFS); check(rd_v & 32'h03, 32'h03);
    // Stop mode freezes the receiver but keeps every register.
    wr(`ESP_MODE_OFS, 32'h1);
    u_esp_ser_src.send(8'h3C, 1'b1, 64);
    repeat (40) @(posedge aclk);
    rd(`ESP_STAT_OFS);
    check(rd_v & 32'h04, 32'h00);
    rd(`ESP_CTRL_OFS);
    check(rd_v, 32'h01);
    wr(`ESP_MODE_OFS, 32'h0);
    q.push_back(8'($urandom));
    u_esp_ser_src.send(q[0], 1'b1, 64);
    repeat (40) @(posedge aclk);
    // The first step of the two-step clear is taken before the break.
    rd(`ESP_STAT_OFS);
    check(rd_v & 32'h04, 32'h04);
    wr(`ESP_MODE_OFS, 32'h2);
    rd(`ESP_DATA_OFS);
    check(rd_v, q.pop_front());
    wr(`ESP_STAT_OFS, 32'hFF);
    rd(`ESP_STAT_OFS);
    check(rd_v & 32'h07, 32'h07);
    wr(`ESP_MODE_OFS, 32'h0);
    rd(`ESP_DATA_OFS);
    rd(`ESP_STAT_OFS);
    check(rd_v & 32'h07, 32'h03);
    wr(`ESP_MODE_OFS, 32'h6);
    wr(`ESP_STAT_OFS, 32'h03);
    wr(`ESP_MODE_OFS, 32'h0);
    rd(`ESP_STAT_OFS);
    check(rd_v & 32'h07, 32'h00);
    complete_run();
  end
endmodule
